// [verilog/eline_protection_select.sv]
// e-line linear protection selector: apb tables plus frame pipeline
// assumes frame descriptors synchronous to pclk, one per cycle max
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module eline_protection_select (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic in_valid,
   input wire eline_pkg::frame_in_t in_frame,
   output logic out_valid,
   output eline_pkg::frame_out_t out_frame
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   // apb answer phases, one-hot
   typedef enum logic [1:0] {
      APB_IDLE = 2'b01,
      APB_DONE = 2'b10
   } apb_phase_t;

   typedef struct packed {
      logic [eline_pkg::PATHS-1:0] path_state;
      eline_pkg::prot_entry_t [eline_pkg::ENTRY_N-1:0] entries;
      logic [eline_pkg::GROUP_N-1:0][7:0] cap;
      logic [eline_pkg::GROUP_N-1:0][7:0] learned;
      eline_pkg::rule_key_t [eline_pkg::RULES-1:0] key;
      eline_pkg::rule_action_t [eline_pkg::RULES-1:0] act;
      logic [eline_pkg::MAP_N-1:0][19:0] map;
      logic [15:0] drops;
      logic [15:0] refused;
      apb_phase_t phase;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic out_valid;
      eline_pkg::frame_out_t out;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function automatic logic in_region(input logic [11:0] addr,
                                      input logic [11:0] base,
                                      input int count);
      in_region = (addr >= base) && (addr < base + 12'(4 * count));
   endfunction

   // ----------------------------------------------------------------
   // register regions
   // ----------------------------------------------------------------
   typedef struct packed {
      logic path;
      logic entry;
      logic cap;
      logic key;
      logic act;
      logic map;
      logic stat;
   } region_t;

   // one decode serves the read mux and the write side alike
   function automatic region_t decode_region(input logic [11:0] addr);
      decode_region.path = in_region(addr, eline_pkg::PATH_BASE,
                                     eline_pkg::PATHS);
      decode_region.entry = in_region(addr, eline_pkg::ENTRY_BASE,
                                      eline_pkg::ENTRY_N);
      decode_region.cap = in_region(addr, eline_pkg::CAP_BASE,
                                    eline_pkg::GROUP_N);
      decode_region.key = in_region(addr, eline_pkg::KEY_BASE,
                                    eline_pkg::RULES);
      decode_region.act = in_region(addr, eline_pkg::ACT_BASE,
                                    eline_pkg::RULES);
      decode_region.map = in_region(addr, eline_pkg::MAP_BASE,
                                    eline_pkg::MAP_N);
      decode_region.stat = (addr == eline_pkg::STAT_ADDR);
   endfunction

   // ----------------------------------------------------------------
   // frame path, combinational part
   // ----------------------------------------------------------------
   eline_pkg::prot_entry_t entry;
   logic path_sel;
   logic drop;
   logic protect;
   logic mep_ok;
   logic count_ok;
   logic rule_hit;
   eline_pkg::rule_action_t rule_act;
   logic by_group;
   logic [7:0] learn_key;
   logic [1:0] grp;
   logic cap_room;
   logic learn_ok;

   always_comb begin
      entry = state_reg.entries[in_frame.isdx];
      // shared pointer: one path-state bit serves many entries
      path_sel = state_reg.path_state[entry.path_idx];
   end

   // ----------------------------------------------------------------
   // standby check and egress rule match
   // ----------------------------------------------------------------
   path_protect_check u_check (
      .protection_code(entry.protection_code),
      .path_selects_protection(path_sel),
      .standby_drop_point(entry.standby_drop_point),
      .drop(drop),
      .protect_path_flag(protect),
      .mep_ok(mep_ok),
      .count_ok(count_ok)
   );

   egress_rule_match u_match (
      .keys(state_reg.key),
      .actions(state_reg.act),
      .egress_port_key(in_frame.egress_port),
      .protect_path_flag(protect),
      .service(in_frame.isdx),
      .hit(rule_hit),
      .action(rule_act)
   );

   // ----------------------------------------------------------------
   // learning key and cap
   // ----------------------------------------------------------------
   always_comb begin
      by_group = (entry.forward_kind == eline_pkg::KIND_GROUP_LEARN);
      learn_key = by_group ? entry.learning_group_index
                           : {4'h0, in_frame.src_port};
      grp = entry.filter_group_id;
      // cap of zero means no limit for that filter group
      cap_room = (state_reg.cap[grp] == eline_pkg::CAP_UNLIMITED)
         || (state_reg.learned[grp] < state_reg.cap[grp]);
      learn_ok = in_frame.learn_req && !drop && cap_room;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic access;
   logic commit;
   logic [31:0] rdata;
   logic mapped;
   region_t region;

   always_comb begin
      state_next = state_reg;
      access = psel && penable;
      commit = access && state_reg.pready;
      region = decode_region(paddr);

      // frame result, one cycle after the descriptor
      state_next.out_valid = in_valid;
      if (in_valid) begin
         state_next.out.drop = drop;
         state_next.out.protect_path_flag = protect;
         state_next.out.mep_ok = mep_ok;
         state_next.out.count_ok = count_ok;
         state_next.out.learn_by_group = by_group;
         state_next.out.learn_key = learn_key;
         state_next.out.learn_ok = learn_ok;
         state_next.out.rule_hit = rule_hit;
         state_next.out.mpls = rule_act.mpls;
         // backup pointer only when flagged and the action asks for it
         state_next.out.encap_pointer = (protect && rule_act.backup_sel)
            ? rule_act.backup_encap_pointer
            : rule_act.encap_pointer;
         state_next.out.inner_label = rule_act.label_from_map
            ? state_reg.map[in_frame.isdx]
            : {8'h00, rule_act.tag_or_label};
         state_next.out.vlan_tag = rule_act.mpls ? 12'h000
            : rule_act.tag_or_label;
         if (drop) begin
            state_next.drops = state_reg.drops + 16'h0001;
         end
         if (learn_ok) begin
            state_next.learned[grp] = state_reg.learned[grp] + 8'h01;
         end
         if (in_frame.learn_req && !drop && !cap_room) begin
            state_next.refused = state_reg.refused + 16'h0001;
         end
      end

      // apb read data and error, one wait state
      mapped = 1'b1;
      rdata = 32'h0000_0000;
      if (region.path) begin
         rdata = {31'h0, state_reg.path_state[paddr[4:2]]};
      end else if (region.entry) begin
         rdata = {13'h0, state_reg.entries[paddr[5:2]]};
      end else if (region.cap) begin
         rdata = {8'h00, state_reg.learned[paddr[3:2]], 8'h00,
                  state_reg.cap[paddr[3:2]]};
      end else if (region.key) begin
         rdata = {22'h0, state_reg.key[paddr[4:2]]};
      end else if (region.act) begin
         rdata = {1'b0, state_reg.act[paddr[4:2]]};
      end else if (region.map) begin
         rdata = {12'h000, state_reg.map[paddr[5:2]]};
      end else if (region.stat) begin
         rdata = {state_reg.refused, state_reg.drops};
      end else begin
         mapped = 1'b0;
      end

      // error flag stands only beside its ready pulse
      state_next.pready = 1'b0;
      state_next.pslverr = 1'b0;
      case (state_reg.phase)
         APB_IDLE: begin
            if (access) begin
               state_next.phase = APB_DONE;
               state_next.pready = 1'b1;
               state_next.prdata = pwrite ? 32'h0000_0000 : rdata;
               state_next.pslverr = !mapped;
            end
         end
         APB_DONE: begin
            // ready lasts one cycle; an access still held is answered again two cycles later
            state_next.phase = APB_IDLE;
         end
         default: begin
            state_next.phase = APB_IDLE;
         end
      endcase

      // writes land at the edge that completes the transfer
      if (commit && pwrite) begin
         if (region.path) begin
            state_next.path_state[paddr[4:2]] = pwdata[0];
         end else if (region.entry) begin
            state_next.entries[paddr[5:2]] = pwdata[18:0];
         end else if (region.cap) begin
            // a new cap restarts the count of that group
            state_next.cap[paddr[3:2]] = pwdata[7:0];
            state_next.learned[paddr[3:2]] = 8'h00;
         end else if (region.key) begin
            state_next.key[paddr[4:2]] = pwdata[9:0];
         end else if (region.act) begin
            state_next.act[paddr[4:2]] = pwdata[30:0];
         end else if (region.map) begin
            state_next.map[paddr[5:2]] = pwdata[19:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '0;
         state_reg.path_state <= eline_pkg::PATH_STATE_RESET;
         state_reg.phase <= APB_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------

   assign prdata = state_reg.prdata;
   assign pready = state_reg.pready;
   assign pslverr = state_reg.pslverr;
   assign out_valid = state_reg.out_valid;
   assign out_frame = state_reg.out;

endmodule

// [common/eline_pkg.sv]
// shared types and constants of the e-line protection selector
// assumes one apb clock domain; tables sit in the selector itself
package eline_pkg;

   // ----------------------------------------------------------------
   // table sizes
   // ----------------------------------------------------------------
   localparam int PATHS = 8;
   localparam int ENTRY_N = 16;
   localparam int GROUP_N = 4;
   localparam int RULES = 8;
   localparam int MAP_N = 16;

   // ----------------------------------------------------------------
   // register map, byte addresses
   // ----------------------------------------------------------------
   localparam logic [11:0] PATH_BASE = 12'h000;
   localparam logic [11:0] ENTRY_BASE = 12'h100;
   localparam logic [11:0] CAP_BASE = 12'h200;
   localparam logic [11:0] KEY_BASE = 12'h300;
   localparam logic [11:0] ACT_BASE = 12'h340;
   localparam logic [11:0] MAP_BASE = 12'h380;
   localparam logic [11:0] STAT_ADDR = 12'h3C0;

   // ----------------------------------------------------------------
   // encodings and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] CODE_NONE = 2'h0;
   localparam logic [1:0] CODE_MARK = 2'h1;
   localparam logic [1:0] CODE_DROP_WORK = 2'h2;
   localparam logic [1:0] CODE_DROP_PROT = 2'h3;
   localparam logic [1:0] KIND_GROUP_LEARN = 2'h3;
   localparam logic [1:0] PT_BEFORE_MEP = 2'h0;
   localparam logic [1:0] PT_BEFORE_COUNT = 2'h1;
   localparam logic [PATHS-1:0] PATH_STATE_RESET = 8'h00;
   localparam logic [7:0] CAP_UNLIMITED = 8'h00;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] filter_group_id;
      logic [7:0] learning_group_index;
      logic [1:0] forward_kind;
      logic [1:0] standby_drop_point;
      logic [2:0] path_idx;
      logic [1:0] protection_code;
   } prot_entry_t;

   typedef struct packed {
      logic valid;
      logic [3:0] service;
      logic protect_path_flag;
      logic [3:0] egress_port_key;
   } rule_key_t;

   typedef struct packed {
      logic mpls;
      logic label_from_map;
      logic backup_sel;
      logic [11:0] tag_or_label;
      logic [7:0] backup_encap_pointer;
      logic [7:0] encap_pointer;
   } rule_action_t;

   typedef struct packed {
      logic [3:0] isdx;
      logic [3:0] src_port;
      logic [3:0] egress_port;
      logic learn_req;
   } frame_in_t;

   typedef struct packed {
      logic drop;
      logic protect_path_flag;
      logic mep_ok;
      logic count_ok;
      logic learn_by_group;
      logic [7:0] learn_key;
      logic learn_ok;
      logic rule_hit;
      logic mpls;
      logic [7:0] encap_pointer;
      logic [19:0] inner_label;
      logic [11:0] vlan_tag;
   } frame_out_t;

endpackage

// [verilog/path_protect_check.sv]
// standby drop and protect marking for one service entry
// assumes code, path state and drop point come from the tables
`timescale 1ns/1ps
module path_protect_check (
   input wire logic [1:0] protection_code,
   input wire logic path_selects_protection,
   input wire logic [1:0] standby_drop_point,
   output logic drop,
   output logic protect_path_flag,
   output logic mep_ok,
   output logic count_ok
);
   always_comb begin
      drop = 1'b0;
      protect_path_flag = 1'b0;
      case (protection_code)
         eline_pkg::CODE_MARK: begin
            protect_path_flag = path_selects_protection;
         end
         eline_pkg::CODE_DROP_WORK: begin
            drop = path_selects_protection;
         end
         eline_pkg::CODE_DROP_PROT: begin
            drop = ~path_selects_protection;
         end
         default: begin
            drop = 1'b0;
         end
      endcase
      // stages before the drop point still see the frame
      mep_ok = ~drop
         | (standby_drop_point != eline_pkg::PT_BEFORE_MEP);
      count_ok = ~drop | ((standby_drop_point != eline_pkg::PT_BEFORE_MEP)
         && (standby_drop_point != eline_pkg::PT_BEFORE_COUNT));
   end
endmodule

// [verilog/egress_rule_match.sv]
// egress rule lookup: lowest matching rule index wins
// assumes rule tables are held stable by the caller
`timescale 1ns/1ps
module egress_rule_match (
   input wire eline_pkg::rule_key_t [eline_pkg::RULES-1:0] keys,
   input wire eline_pkg::rule_action_t [eline_pkg::RULES-1:0] actions,
   input wire logic [3:0] egress_port_key,
   input wire logic protect_path_flag,
   input wire logic [3:0] service,
   output logic hit,
   output eline_pkg::rule_action_t action
);
   logic [eline_pkg::RULES-1:0] match;

   genvar g;
   generate
      for (g = 0; g < eline_pkg::RULES; g = g + 1) begin : g_rule
         assign match[g] = keys[g].valid
            && (keys[g].egress_port_key == egress_port_key)
            && (keys[g].protect_path_flag == protect_path_flag)
            && (keys[g].service == service);
      end
   endgenerate

   always_comb begin
      hit = 1'b0;
      action = '0;
      for (int i = eline_pkg::RULES - 1; i >= 0; i--) begin
         if (match[i]) begin
            hit = 1'b1;
            action = actions[i];
         end
      end
   end
endmodule

// [verification/eline_protection_select_chk.sv]
// port checker of the protection selector
// assumes it is bound to the top module and sees its ports only
`timescale 1ns/1ps
module eline_protection_select_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic in_valid,
   input wire eline_pkg::frame_in_t in_frame,
   input wire logic out_valid,
   input wire eline_pkg::frame_out_t out_frame
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ------------------------------------------------------------
   // sequences
   // ------------------------------------------------------------
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   sequence s_done;
      pready ##1 !pready;
   endsequence
   sequence s_took;
      in_valid ##1 out_valid;
   endsequence
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   AST_ANSWER: assert property (s_wait |=> s_done)
      else $error("apb answer late or too long");
   AST_ERR_READY: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   AST_FRAME_LAT: assert property (in_valid |-> s_took)
      else $error("frame result not one cycle later");
   AST_NO_STRAY: assert property (out_valid |-> $past(in_valid))
      else $error("result without a descriptor");
   AST_DROP_NO_LEARN: assert property (
      out_valid && out_frame.drop |-> !out_frame.learn_ok)
      else $error("dropped frame learned");
   AST_KEPT_PASSES: assert property (
      out_valid && !out_frame.drop |-> out_frame.mep_ok && out_frame.count_ok)
      else $error("kept frame gated");
   AST_POINT_ORDER: assert property (
      out_valid && out_frame.count_ok |-> out_frame.mep_ok)
      else $error("counted but not seen by mep");
   AST_PORT_LEARN: assert property (
      out_valid && !out_frame.learn_by_group
      |-> out_frame.learn_key == {4'h0, $past(in_frame.src_port)})
      else $error("port learn key wrong");
   AST_LEARN_ASK: assert property (
      out_valid && out_frame.learn_ok |-> $past(in_frame.learn_req))
      else $error("learned without request");
   AST_MISS_ZERO: assert property (
      out_valid && !out_frame.rule_hit
      |-> out_frame.encap_pointer == 8'h00 && !out_frame.mpls)
      else $error("miss carries an action");
   AST_MPLS_UNTAGGED: assert property (
      out_valid && out_frame.mpls |-> out_frame.vlan_tag == 12'h000)
      else $error("mpls frame has vlan tag");
endmodule
bind eline_protection_select eline_protection_select_chk chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
   .in_frame(in_frame), .out_valid(out_valid), .out_frame(out_frame));

// [verification/frame_peer.sv]
// network peer model: hands frame descriptors to the selector
// assumes the bench calls send from one thread, one at a time
`timescale 1ns/1ps
module frame_peer (
   input wire logic pclk,
   output logic in_valid,
   output eline_pkg::frame_in_t in_frame
);
   initial begin
      in_valid = 1'b0;
      in_frame = '0;
   end
   // drives one descriptor of isdx, source, egress port and learn request for one cycle
   task automatic send(input logic [3:0] isdx, input logic [3:0] src,
                       input logic [3:0] egr, input logic learn);
      @(posedge pclk);
      in_valid <= 1'b1;
      in_frame <= {isdx, src, egr, learn};
      @(posedge pclk);
      in_valid <= 1'b0;
      in_frame <= ~in_frame; // stale bits flip so nothing leans on them
   endtask
endmodule

// [verification/eline_protection_select_tb.sv]
// self-checking bench of the protection selector
// assumes the bound checker and the frame peer model beside it
`timescale 1ns/1ps
module eline_protection_select_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic in_valid, out_valid;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   eline_pkg::frame_in_t in_frame;
   eline_pkg::frame_out_t out_frame, got;
   int num_errors = 0;
   int tests_run = 0;
   eline_protection_select dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .in_valid(in_valid), .in_frame(in_frame), .out_valid(out_valid),
      .out_frame(out_frame));
   frame_peer peer (.pclk(pclk), .in_valid(in_valid), .in_frame(in_frame));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic end_sim;
      if (num_errors == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         num_errors++;
         end_sim();
      end
      rdata = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic frame(input logic [3:0] isdx, input logic learn,
                        input logic [3:0] egr);
      peer.send(isdx, 4'h6, egr, learn);
      #1;
      check({31'h0, out_valid}, 32'h1);
      got = out_frame;
   endtask
   // code, path, drop point, forward kind, group index; filter group 1
   function automatic logic [31:0] cfg(logic [1:0] c, logic [2:0] p,
      logic [1:0] pt, logic [1:0] k, logic [7:0] g);
      return {13'h0, 2'h1, g, k, pt, p, c};
   endfunction
   // ------------------------------------------------------------
   // sequence of tests
   // ------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, eline_pkg::PATH_BASE + 12'(4 * i), 32'h0);
         check(rdata, 32'h0);
      end
      apb(1'b0, 12'hFF0, 32'h0);
      check({31'h0, e}, 32'h1);
      check(rdata, 32'h0);
      // working and protection entries share one group index
      apb(1'b1, 12'h100, cfg(eline_pkg::CODE_MARK, 3'h2, 2'h0, 2'h0, 8'h0));
      apb(1'b1, 12'h104, cfg(eline_pkg::CODE_DROP_WORK, 3'h2, 2'h0,
          eline_pkg::KIND_GROUP_LEARN, 8'h5A));
      apb(1'b1, 12'h108, cfg(eline_pkg::CODE_DROP_PROT, 3'h2, 2'h3,
          eline_pkg::KIND_GROUP_LEARN, 8'h5A));
      apb(1'b1, 12'h10C, cfg(eline_pkg::CODE_MARK, 3'h2, 2'h0, 2'h0, 8'h0));
      apb(1'b1, 12'h300, 32'h00000213);
      apb(1'b1, 12'h304, 32'h00000203);
      apb(1'b1, 12'h340, 32'h5ABC2211);
      apb(1'b1, 12'h344, 32'h01234433);
      apb(1'b1, 12'h380, 32'h000BEEF5);
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, 12'h008, 32'(s));
         frame(4'h0, 1'b0, 4'h3);
         check({31'h0, got.protect_path_flag}, 32'(s));
         check({24'h0, got.encap_pointer}, s ? 32'h22 : 32'h33);
         check({31'h0, got.mpls}, 32'(s));
         check({20'h0, got.vlan_tag}, s ? 32'h0 : 32'h123);
         check({12'h0, got.inner_label}, s ? 32'hABC : 32'h123);
         frame(4'h3, 1'b0, 4'h3);
         check({31'h0, got.protect_path_flag}, 32'(s));
         frame(4'h1, 1'b0, 4'h3);
         check({31'h0, got.drop}, 32'(s));
         frame(4'h2, 1'b0, 4'h3);
         check({31'h0, got.drop}, 32'(1 - s));
      end
      for (int pt = 0; pt < 4; pt++) begin
         apb(1'b1, 12'h104, cfg(eline_pkg::CODE_DROP_WORK, 3'h2, 2'(pt),
             eline_pkg::KIND_GROUP_LEARN, 8'h5A));
         frame(4'h1, 1'b1, 4'h3);
         check({30'h0, got.mep_ok, got.count_ok},
               {30'h0, pt != 0, pt >= 2});
      end
      frame(4'h0, 1'b1, 4'h3);
      check({24'h0, got.learn_key}, 32'h06);
      apb(1'b1, 12'h204, 32'h00000002);
      for (int n = 0; n < 3; n++) begin
         frame(4'h2, 1'b1, 4'h3);
         check({23'h0, got.learn_by_group, got.learn_key}, 32'h15A);
         check({31'h0, got.learn_ok}, 32'(n < 2));
      end
      apb(1'b0, 12'h204, 32'h0);
      check(rdata & 32'h00FF0000, 32'h00020000);
      check({31'h0, e}, 32'h0);
      apb(1'b1, 12'h3C0, 32'hFFFFFFFF);
      apb(1'b0, 12'h3C0, 32'h0);
      check({16'h0, rdata[31:16]}, 32'h1);
      check({16'h0, rdata[15:0]}, 32'h6);
      apb(1'b1, 12'h340, 32'h6ABC2211);
      frame(4'h0, 1'b0, 4'h3);
      check({12'h0, got.inner_label}, 32'hBEEF5);
      check({24'h0, got.encap_pointer}, 32'h11);
      frame(4'h0, 1'b0, 4'h5);
      check({31'h0, got.rule_hit}, 32'h0);
      // path state back to working after a reset mid-run
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h008, 32'h0);
      check(rdata, 32'h0);
      end_sim();
   end
endmodule
